// File: rtl/mmd_cfg.svh
/*
 * Constants of the memory map and external bus decoder: map boundaries,
 * register-file addresses, expanded bank numbers and bus timing counts.
 * Assumes inclusion by the decoder only.
 */
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH

// ****************************************************************
// Program and data memory map
// ****************************************************************
`define MMD_VEC_END 16'h000C
`define MMD_ROM_TOP 16'h0FFF
`define MMD_DATA_BASE 16'h1000
`define MMD_PC_RESET 16'h000C
`define MMD_NOP 8'hFF

// ****************************************************************
// Register file
// ****************************************************************
`define MMD_RP_ADDR 8'hFD
`define MMD_P3M_ADDR 8'hF7
`define MMD_P3M_DM_LO 3
`define MMD_P3M_DM_HI 4
`define MMD_PORT3_ADDR 8'h03
`define MMD_P34_BIT 4
`define MMD_BANK_STD 4'h0
`define MMD_BANK_SPI 4'hC
`define MMD_BANK_CTL 4'hF
`define MMD_SPI_COMPARE 4'h0
`define MMD_SPI_SHIFT 4'h1
`define MMD_SPI_CONTROL 4'h2
`define MMD_PORT_CONFIG 4'h0
`define MMD_STOP_RECOVERY 4'hB
`define MMD_WATCHDOG_MODE 4'hF
`define MMD_RSV_READ 8'h00

// ****************************************************************
// External bus timing
// ****************************************************************
`define MMD_DS_CYCLES 3'd4

`endif

// File: rtl/mmd_pkg.sv
/*
 * Types of the memory map and external bus decoder: request and answer
 * carriers, expanded registers, sequencer states and the state record.
 * Assumes mmd_cfg.svh for the numbers.
 */
package mmd_pkg;

    typedef enum logic [2:0] {K_FETCH, K_VECTOR, K_JUMP, K_LDC, K_LDE, K_REG} mmd_kind_type;

    typedef enum logic [2:0] {ST_IDLE, ST_ROM, ST_EXT_ADDR, ST_EXT_DATA, ST_EXT_END} mmd_state_type;

    typedef struct packed {
        logic valid;
        mmd_kind_type kind;
        logic write;
        logic working;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mmd_req_type;

    typedef struct packed {
        logic valid;
        logic blocked;
        logic fault;
        logic [7:0] data;
    } mmd_rsp_type;

    typedef struct packed {
        logic [7:0] spi_compare;
        logic [7:0] spi_shift_data;
        logic [7:0] spi_control;
        logic [7:0] port_config;
        logic [7:0] stop_recovery;
        logic [7:0] watchdog_mode;
    } mmd_ext_regs_type;

    typedef struct packed {
        mmd_state_type state;
        mmd_req_type cur;
        logic [2:0] cnt;
        logic [15:0] program_counter;
        logic [255:0][7:0] regs;
        mmd_ext_regs_type ext;
        logic [1:0] strap_meta;
        logic [1:0] strap;
        logic [7:0] mux_meta;
        logic [7:0] mux_sync;
        logic ready;
        mmd_rsp_type rsp;
        logic [15:0] rom_addr;
        logic [7:0] high_address;
        logic [7:0] mux_out;
        logic mux_oe;
        logic address_strobe_n;
        logic data_strobe_n;
        logic read_write;
        logic data_space_n;
        logic port3_bit4;
    } mmd_regs_type;

endpackage

// File: rtl/mmd_decoder.sv
/*
 * Memory map and external bus decoder of the 8-bit core: program counter,
 * program memory decode, internal ROM port, expanded register banks and the
 * multiplexed external memory cycle.
 * Assumes one clock, an asynchronous internal ROM whose rom_data_in is valid
 * for rom_addr_out in the same cycle, and straps and bus pins from outside.
 */
`include "mmd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module mmd_decoder
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire mmd_pkg::mmd_req_type req_in,
    output logic ready_out,
    output mmd_pkg::mmd_rsp_type rsp_out,
    input wire logic has_ext_ports_in,
    input wire logic rom_protect_in,
    output logic [15:0] rom_addr_out,
    input wire logic [7:0] rom_data_in,
    output logic [7:0] high_address_out,
    input wire logic [7:0] muxed_addr_data_in,
    output logic [7:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe_out,
    output logic address_strobe_n_out,
    output logic data_strobe_n_out,
    output logic read_write_out,
    output logic data_space_n_out,
    output logic port3_bit4_out,
    output logic [15:0] program_counter_out,
    output mmd_pkg::mmd_ext_regs_type ext_regs_out
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic in_rom(input logic [15:0] a);
        in_rom = (a <= `MMD_ROM_TOP);
    endfunction

    function automatic logic [7:0] eff_reg(input logic [7:0] a, input logic wk,
                                           input logic [7:0] rp);
        eff_reg = wk ? {rp[7:4], a[3:0]} : a;
    endfunction

    mmd_pkg::mmd_regs_type s;
    mmd_pkg::mmd_regs_type next_s;
    logic accept;
    logic [7:0] rp;

    assign accept = req_in.valid && s.ready;
    assign rp = s.regs[`MMD_RP_ADDR];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [15:0] a;
        logic [7:0] e;
        logic [3:0] bank;
        logic remap;
        logic has_ext;
        logic protect;
        a = req_in.addr;
        e = eff_reg(req_in.addr[7:0], req_in.working, rp);
        bank = rp[3:0];
        remap = (e[7:4] == 4'h0) && (bank != `MMD_BANK_STD);
        has_ext = s.strap[1];
        protect = s.strap[0];
        next_s = s;
        next_s.strap_meta = {has_ext_ports_in, rom_protect_in};
        next_s.strap = s.strap_meta;
        next_s.mux_meta = muxed_addr_data_in;
        next_s.mux_sync = s.mux_meta;
        next_s.rsp.valid = 1'b0;
        next_s.rsp.blocked = 1'b0;
        next_s.rsp.fault = 1'b0;
        case (s.state)
            mmd_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    next_s.cur = req_in;
                    next_s.rsp.data = 8'h00;
                    case (req_in.kind)
                        mmd_pkg::K_JUMP:
                        begin
                            next_s.program_counter = req_in.addr;
                            next_s.rsp.valid = 1'b1;
                        end
                        mmd_pkg::K_FETCH, mmd_pkg::K_VECTOR:
                        begin
                            if (req_in.kind == mmd_pkg::K_FETCH)
                            begin
                                a = s.program_counter;
                                // Plain 16-bit increment wraps FFFF to 0000.
                                next_s.program_counter = s.program_counter + 16'h0001;
                            end
                            next_s.cur.addr = a;
                            next_s.cur.write = 1'b0;
                            if ((req_in.kind == mmd_pkg::K_FETCH) == (a < `MMD_VEC_END))
                            begin
                                // Vectors are table data, not code.
                                next_s.rsp.valid = 1'b1;
                                next_s.rsp.fault = 1'b1;
                                next_s.rsp.data = `MMD_NOP;
                            end
                            else if (in_rom(a))
                            begin
                                next_s.rom_addr = a;
                                next_s.state = mmd_pkg::ST_ROM;
                            end
                            else if (has_ext)
                            begin
                                next_s.data_space_n = 1'b1;
                                next_s.state = mmd_pkg::ST_EXT_ADDR;
                            end
                            else
                            begin
                                next_s.rsp.valid = 1'b1;
                                next_s.rsp.data = `MMD_NOP;
                            end
                        end
                        mmd_pkg::K_LDC, mmd_pkg::K_LDE:
                        begin
                            // Data loads below the data window land in program space.
                            if ((req_in.kind == mmd_pkg::K_LDE) ? (a < `MMD_DATA_BASE)
                                                                 : in_rom(a))
                            begin
                                next_s.rsp.valid = 1'b1;
                                if (protect)
                                begin
                                    next_s.rsp.blocked = 1'b1;
                                end
                                else if (req_in.write)
                                begin
                                    next_s.rsp.fault = 1'b1;
                                end
                                else
                                begin
                                    next_s.rsp.valid = 1'b0;
                                    next_s.rom_addr = a;
                                    next_s.state = mmd_pkg::ST_ROM;
                                end
                            end
                            else if (has_ext)
                            begin
                                // Space select follows the instruction kind.
                                next_s.data_space_n = (req_in.kind != mmd_pkg::K_LDE);
                                next_s.state = mmd_pkg::ST_EXT_ADDR;
                            end
                            else
                            begin
                                next_s.rsp.valid = 1'b1;
                                next_s.rsp.data = `MMD_NOP;
                            end
                        end
                        mmd_pkg::K_REG:
                        begin
                            // The program counter has no address here.
                            next_s.rsp.valid = 1'b1;
                            if (remap)
                            begin
                                // Only 00h to 0Fh follow the selected bank.
                                case ({bank, e[3:0]})
                                    {`MMD_BANK_SPI, `MMD_SPI_COMPARE}:
                                    begin
                                        next_s.rsp.data = s.ext.spi_compare;
                                        if (req_in.write)
                                            next_s.ext.spi_compare = req_in.wdata;
                                    end
                                    {`MMD_BANK_SPI, `MMD_SPI_SHIFT}:
                                    begin
                                        next_s.rsp.data = s.ext.spi_shift_data;
                                        if (req_in.write)
                                            next_s.ext.spi_shift_data = req_in.wdata;
                                    end
                                    {`MMD_BANK_SPI, `MMD_SPI_CONTROL}:
                                    begin
                                        next_s.rsp.data = s.ext.spi_control;
                                        if (req_in.write)
                                            next_s.ext.spi_control = req_in.wdata;
                                    end
                                    {`MMD_BANK_CTL, `MMD_PORT_CONFIG}:
                                    begin
                                        next_s.rsp.data = s.ext.port_config;
                                        if (req_in.write)
                                            next_s.ext.port_config = req_in.wdata;
                                    end
                                    {`MMD_BANK_CTL, `MMD_STOP_RECOVERY}:
                                    begin
                                        next_s.rsp.data = s.ext.stop_recovery;
                                        if (req_in.write)
                                            next_s.ext.stop_recovery = req_in.wdata;
                                    end
                                    {`MMD_BANK_CTL, `MMD_WATCHDOG_MODE}:
                                    begin
                                        next_s.rsp.data = s.ext.watchdog_mode;
                                        if (req_in.write)
                                            next_s.ext.watchdog_mode = req_in.wdata;
                                    end
                                    default:
                                    begin
                                        next_s.rsp.data = `MMD_RSV_READ;
                                    end
                                endcase
                            end
                            else
                            begin
                                // Ports sit at 00h to 03h of bank 0.
                                next_s.rsp.data = s.regs[e];
                                if (req_in.write)
                                    next_s.regs[e] = req_in.wdata;
                            end
                        end
                        default:
                        begin
                            next_s.rsp.valid = 1'b1;
                            next_s.rsp.fault = 1'b1;
                        end
                    endcase
                    if (next_s.state == mmd_pkg::ST_EXT_ADDR)
                    begin
                        // Address phase drives both bytes.
                        next_s.address_strobe_n = 1'b0;
                        next_s.high_address = next_s.cur.addr[15:8];
                        next_s.mux_out = next_s.cur.addr[7:0];
                        next_s.mux_oe = 1'b1;
                        next_s.read_write = !next_s.cur.write;
                    end
                end
            end
            mmd_pkg::ST_ROM:
            begin
                next_s.rsp.valid = 1'b1;
                next_s.rsp.data = rom_data_in;
                next_s.state = mmd_pkg::ST_IDLE;
            end
            mmd_pkg::ST_EXT_ADDR:
            begin
                // Rising address strobe latches the low byte outside.
                next_s.address_strobe_n = 1'b1;
                next_s.data_strobe_n = 1'b0;
                next_s.mux_out = s.cur.wdata;
                next_s.mux_oe = s.cur.write;
                next_s.cnt = 3'd1;
                next_s.state = mmd_pkg::ST_EXT_DATA;
            end
            mmd_pkg::ST_EXT_DATA:
            begin
                // The strobe stays low long enough to cover the pin synchroniser.
                next_s.cnt = s.cnt + 3'd1;
                if (s.cnt == `MMD_DS_CYCLES)
                begin
                    next_s.data_strobe_n = 1'b1;
                    next_s.rsp.valid = 1'b1;
                    next_s.rsp.data = s.cur.write ? 8'h00 : s.mux_sync;
                    next_s.state = mmd_pkg::ST_EXT_END;
                end
            end
            mmd_pkg::ST_EXT_END:
            begin
                next_s.mux_oe = 1'b0;
                next_s.read_write = 1'b1;
                next_s.data_space_n = 1'b1;
                next_s.state = mmd_pkg::ST_IDLE;
            end
            default:
            begin
                next_s.state = mmd_pkg::ST_IDLE;
            end
        endcase
        next_s.ready = (next_s.state == mmd_pkg::ST_IDLE);
        // Pin shows space select only once port-3 mode bits route it.
        next_s.port3_bit4 =
            (next_s.regs[`MMD_P3M_ADDR][`MMD_P3M_DM_HI:`MMD_P3M_DM_LO] == 2'b11)
            ? next_s.data_space_n : next_s.regs[`MMD_PORT3_ADDR][`MMD_P34_BIT];
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s <= '0;
            s.state <= mmd_pkg::ST_IDLE;
            s.program_counter <= `MMD_PC_RESET;
            s.address_strobe_n <= 1'b1;
            s.data_strobe_n <= 1'b1;
            s.read_write <= 1'b1;
            s.data_space_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign ready_out = s.ready;
    assign rsp_out = s.rsp;
    assign rom_addr_out = s.rom_addr;
    assign high_address_out = s.high_address;
    assign muxed_addr_data_out = s.mux_out;
    assign muxed_addr_data_oe_out = s.mux_oe;
    assign address_strobe_n_out = s.address_strobe_n;
    assign data_strobe_n_out = s.data_strobe_n;
    assign read_write_out = s.read_write;
    assign data_space_n_out = s.data_space_n;
    assign port3_bit4_out = s.port3_bit4;
    assign program_counter_out = s.program_counter;
    assign ext_regs_out = s.ext;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    chk_pc_wrap: assert property (
        accept && req_in.kind == mmd_pkg::K_FETCH && s.program_counter == 16'hFFFF
        |=> s.program_counter == 16'h0000)
        else $error("program counter did not wrap to zero");

    chk_vector_fetch: assert property (
        accept && req_in.kind == mmd_pkg::K_FETCH && s.program_counter < 16'h000C
        |=> s.rsp.valid && s.rsp.fault && s.address_strobe_n)
        else $error("fetch from vector area not refused");

    chk_rom_fetch: assert property (
        accept && req_in.kind == mmd_pkg::K_FETCH && s.program_counter >= 16'h000C
        && s.program_counter <= 16'h0FFF
        |=> rom_addr_out == $past(s.program_counter) ##1 s.rsp.valid)
        else $error("internal ROM fetch not served");

    chk_ext_fetch: assert property (
        accept && req_in.kind == mmd_pkg::K_FETCH && s.program_counter > 16'h0FFF
        && s.strap[1] |=> !address_strobe_n_out && data_space_n_out)
        else $error("external fetch cycle not started");

    chk_no_port_nop: assert property (
        accept && req_in.kind == mmd_pkg::K_FETCH && s.program_counter > 16'h0FFF
        && !s.strap[1] |=> s.rsp.valid && s.rsp.data == 8'hFF && address_strobe_n_out)
        else $error("portless fetch did not yield a no-op");

    chk_protect_block: assert property (
        accept && req_in.kind inside {mmd_pkg::K_LDC, mmd_pkg::K_LDE}
        && req_in.addr <= 16'h0FFF && s.strap[0]
        |=> s.rsp.blocked && s.state == mmd_pkg::ST_IDLE)
        else $error("protected ROM load not blocked");

    chk_addr_phase: assert property (
        !address_strobe_n_out |-> high_address_out == s.cur.addr[15:8]
        && muxed_addr_data_out == s.cur.addr[7:0] && muxed_addr_data_oe_out)
        else $error("address phase shows wrong address");

    chk_strobe_frame: assert property (
        $fell(address_strobe_n_out) |=> $rose(address_strobe_n_out)
        && $fell(data_strobe_n_out) ##0 !data_strobe_n_out [*4] ##1 data_strobe_n_out)
        else $error("strobe framing wrong");

    chk_space_select: assert property (
        $fell(address_strobe_n_out) |->
        data_space_n_out == (s.cur.kind != mmd_pkg::K_LDE))
        else $error("space select does not follow instruction");

    chk_bank_remap: assert property (
        accept && req_in.kind == mmd_pkg::K_REG && req_in.write && !req_in.working
        && req_in.addr[7:4] == 4'h0 && rp[3:0] != 4'h0
        |=> s.regs[$past(req_in.addr[7:0])] == $past(s.regs[req_in.addr[7:0]]))
        else $error("remapped write reached standard file");

endmodule

`default_nettype wire

// File: testbench/mmd_ext_mem.sv
/* External memory model on the multiplexed bus.
   Assumes the decoder's strobes, direction and bus outputs. */
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_mem
(
    input wire logic clk_in,
    input wire logic as_n_in,
    input wire logic ds_n_in,
    input wire logic rw_in,
    input wire logic [7:0] high_in,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic [7:0] wbyte_out
);
    logic [15:0] addr = 16'h0000;
    logic [7:0] last = 8'h00;
    initial wbyte_out = 8'h00;
    always @(posedge clk_in)
    begin
        if (!as_n_in) addr <= {high_in, ad_in};
        if (!ds_n_in && !rw_in) wbyte_out <= ad_in;
        if (!ds_n_in && rw_in) last <= ad_out;
    end
    // A released bus shows the inverse, so stale data never matches.
    assign ad_out = (!ds_n_in && rw_in) ? (addr[7:0] ^ 8'h5A) : ~last;
endmodule
`default_nettype wire

// File: testbench/test_memory_map_and_ext_bus_decode.sv
/* Self-checking bench of the decoder.
   Assumes a ROM image of address xor 3C and the external memory model. */
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_and_ext_bus_decode;
    logic mclk_in = 1'b0, rst_in = 1'b1, ready, ad_oe, as_n, ds_n, rw, dm_n, p34, lo;
    logic hx = 1'b1, prot = 1'b0;
    logic [7:0] high, ad_in, ad_out, wbyte;
    logic [15:0] rom_a, pc;
    mmd_pkg::mmd_req_type r = '0;
    mmd_pkg::mmd_rsp_type rsp, got;
    mmd_pkg::mmd_ext_regs_type ext;
    int fails = 0, compares = 0;
    always #2.5 mclk_in = ~mclk_in;
    mmd_decoder DUT (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(r), .ready_out(ready),
        .rsp_out(rsp), .has_ext_ports_in(hx), .rom_protect_in(prot), .rom_addr_out(rom_a),
        .rom_data_in(rom_a[7:0] ^ 8'h3C), .high_address_out(high),
        .muxed_addr_data_in(ad_in), .muxed_addr_data_out(ad_out),
        .muxed_addr_data_oe_out(ad_oe), .address_strobe_n_out(as_n),
        .data_strobe_n_out(ds_n), .read_write_out(rw), .data_space_n_out(dm_n),
        .port3_bit4_out(p34), .program_counter_out(pc), .ext_regs_out(ext));
    mmd_ext_mem mem (.clk_in(mclk_in), .as_n_in(as_n), .ds_n_in(ds_n), .rw_in(rw),
        .high_in(high), .ad_in(ad_out), .ad_out(ad_in), .wbyte_out(wbyte));
    task final_report();
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    // Issues one request and waits, bounded, for its answer.
    task go(mmd_pkg::mmd_kind_type k, logic w, logic [15:0] a, logic [7:0] d);
        int i;
        for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge mclk_in);
        if (i == 40)
        begin
            fails++;
            final_report();
        end
        r = '{1'b1, k, w, 1'b0, a, d};
        @(negedge mclk_in);
        r.valid = 1'b0;
        lo = 1'b1;
        for (i = 0; i < 40 && rsp.valid !== 1'b1; i++)
        begin
            lo = lo & dm_n;
            @(negedge mclk_in);
        end
        if (i == 40)
        begin
            fails++;
            final_report();
        end
        got = rsp;
        // Let an edge pass so the next request never re-raises valid in this step.
        @(negedge mclk_in);
    endtask
    task s_regs();
        go(mmd_pkg::K_REG, 1, 16'h00FD, 8'h0C);
        go(mmd_pkg::K_REG, 1, 16'h0002, 8'h5C);
        chk("spi_control", 16'h5C, ext.spi_control);
        go(mmd_pkg::K_REG, 1, 16'h000B, 8'h11);
        go(mmd_pkg::K_REG, 0, 16'h000B, 8'h00);
        chk("reserved", 16'h00, got.data);
        go(mmd_pkg::K_REG, 1, 16'h0012, 8'h99);
        go(mmd_pkg::K_REG, 1, 16'h00FD, 8'h0F);
        go(mmd_pkg::K_REG, 1, 16'h000B, 8'h77);
        chk("stop_recovery", 16'h77, ext.stop_recovery);
        go(mmd_pkg::K_REG, 1, 16'h00FD, 8'h00);
        go(mmd_pkg::K_REG, 0, 16'h0012, 8'h00);
        chk("gpr12", 16'h99, got.data);
        go(mmd_pkg::K_REG, 1, 16'h0003, 8'h00);
        go(mmd_pkg::K_REG, 1, 16'h00F7, 8'h18);
        chk("p34", 16'h1, p34);
    endtask
    task s_mem();
        go(mmd_pkg::K_JUMP, 0, 16'h000C, 8'h00);
        go(mmd_pkg::K_FETCH, 0, 16'h0000, 8'h00);
        chk("rom", 16'h30, got.data);
        chk("pc", 16'h000D, pc);
        go(mmd_pkg::K_VECTOR, 0, 16'h0004, 8'h00);
        chk("vector", 16'h38, got.data);
        go(mmd_pkg::K_JUMP, 0, 16'h0002, 8'h00);
        go(mmd_pkg::K_FETCH, 0, 16'h0000, 8'h00);
        chk("vec_fault", 16'h1, got.fault);
        go(mmd_pkg::K_LDE, 0, 16'h1234, 8'h00);
        chk("lde", 16'h6E, got.data);
        chk("lde_dm", 16'h0, lo);
        chk("high", 16'h12, high);
        go(mmd_pkg::K_LDE, 1, 16'h2345, 8'hC3);
        chk("store", 16'hC3, wbyte);
        go(mmd_pkg::K_JUMP, 0, 16'h8001, 8'h00);
        go(mmd_pkg::K_FETCH, 0, 16'h0000, 8'h00);
        chk("ext_fetch", 16'h5B, got.data);
        go(mmd_pkg::K_LDC, 0, 16'h8002, 8'h00);
        chk("ldc_dm", 16'h1, lo);
    endtask
    task s_straps();
        hx = 1'b0;
        prot = 1'b1;
        repeat (4) @(negedge mclk_in);
        go(mmd_pkg::K_JUMP, 0, 16'hFFFF, 8'h00);
        go(mmd_pkg::K_FETCH, 0, 16'h0000, 8'h00);
        chk("nop", 16'hFF, got.data);
        chk("wrap", 16'h0000, pc);
        go(mmd_pkg::K_LDC, 0, 16'h0100, 8'h00);
        chk("ldc_block", 16'h1, got.blocked);
        go(mmd_pkg::K_LDE, 0, 16'h0100, 8'h00);
        chk("lde_block", 16'h1, got.blocked);
    endtask
    initial
    begin
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        s_regs();
        s_mem();
        s_straps();
        final_report();
    end
endmodule
`default_nettype wire
